//--- common/nvm_pkg.sv
`default_nettype none
package nvm_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_FLAGS   = 10'h00d;
    localparam logic [9:0] IDX_MASK    = 10'h08d;
    localparam logic [9:0] IDX_DATA_LO = 10'h10c;
    localparam logic [9:0] IDX_ADDR_LO = 10'h10d;
    localparam logic [9:0] IDX_DATA_HI = 10'h10e;
    localparam logic [9:0] IDX_ADDR_HI = 10'h10f;
    localparam logic [9:0] IDX_CTL     = 10'h18c;
    localparam logic [9:0] IDX_KEY     = 10'h18d;

    // control and flags register fields, register reset value
    localparam int unsigned CTL_SPACE  = 7;
    localparam int unsigned CTL_ERR    = 3;
    localparam int unsigned CTL_PERMIT = 2;
    localparam int unsigned CTL_WR     = 1;
    localparam int unsigned CTL_RD     = 0;
    localparam int unsigned FLAG_DONE  = 4;
    localparam logic [7:0]  REG_RESET  = 8'h00;

    // unlock keys
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // flash write-protect region limits (exclusive upper ends)
    localparam logic [12:0] LOCK_END_00 = 13'h1000;
    localparam logic [12:0] LOCK_END_01 = 13'h0800;
    localparam logic [12:0] LOCK_END_10 = 13'h0100;

    // timing
    localparam int unsigned CLK_KHZ       = 100000;
    localparam int unsigned PWRT_MS       = 72;
    localparam int unsigned COMMIT_MS     = 4;
    localparam int unsigned PWRT_CYCLES   = PWRT_MS * CLK_KHZ;
    localparam int unsigned COMMIT_CYCLES = COMMIT_MS * CLK_KHZ;
    localparam logic [1:0]  FETCH_SKIP    = 2'h2;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : nvm_pkg
`default_nettype wire

//--- common/nvm_eng_if.sv
`default_nettype none
interface nvm_eng_if;
    logic        start;
    logic        space;
    logic [12:0] addr;
    logic [13:0] wdata;
    logic        busy;
    logic        hold;
    logic        done;
    logic        mem_we;
    logic        mem_erase;
    logic        mem_space;
    logic [12:0] mem_addr;
    logic [13:0] mem_wdata;

    modport ctrl (output start, space, addr, wdata,
                  input busy, hold, done, mem_we, mem_erase, mem_space, mem_addr, mem_wdata);
    modport eng  (input start, space, addr, wdata,
                  output busy, hold, done, mem_we, mem_erase, mem_space, mem_addr, mem_wdata);
endinterface : nvm_eng_if
`default_nettype wire

//--- design/nvm_commit.sv
`default_nettype none
module nvm_commit #(
    parameter int unsigned COMMIT_CYCLES = nvm_pkg::COMMIT_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control side
    nvm_eng_if.eng   e
);
    localparam int unsigned CW = $clog2(COMMIT_CYCLES + 1);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_ERASE = 3'b011,
        ST_PROG  = 3'b010,
        ST_DONE  = 3'b110
    } commit_state_t;

    commit_state_t st_q;
    logic [CW-1:0] tmr_q;
    logic [1:0]    idx_q;
    logic          flash_q;
    logic [12:0]   base_q;
    logic [7:0]    ee_q;
    logic [13:0]   buf_q [4];

    // block buffer, slot picked by the low address bits
    always_ff @(posedge mclk) begin
        if (e.start && e.space) begin
            buf_q[e.addr[1:0]] <= e.wdata;
        end
        if (e.start && !e.space) begin
            ee_q <= e.wdata[7:0];
        end
    end

    // sequencer: wait out the write time, erase (flash block only), then program
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q    <= ST_IDLE;
            tmr_q   <= '0;
            idx_q   <= 2'h0;
            flash_q <= 1'b0;
            base_q  <= 13'h0000;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (e.start) begin
                        flash_q <= e.space;
                        base_q  <= e.addr;
                        idx_q   <= 2'h0;
                        tmr_q   <= CW'(COMMIT_CYCLES - 1);
                        // early words only park in the buffer
                        if (e.space && e.addr[1:0] != 2'h3) begin
                            st_q <= ST_DONE;
                        end else begin
                            st_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (tmr_q == '0) begin
                        st_q <= flash_q ? ST_ERASE : ST_PROG;
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                ST_ERASE: st_q <= ST_PROG;
                ST_PROG: begin
                    idx_q <= idx_q + 2'h1;
                    if (!flash_q || idx_q == 2'h3) begin
                        st_q <= ST_DONE;
                    end
                end
                ST_DONE: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // status and memory strobes straight from the state
    assign e.busy      = st_q != ST_IDLE;
    assign e.hold      = flash_q && (st_q == ST_WAIT || st_q == ST_ERASE || st_q == ST_PROG);
    assign e.done      = st_q == ST_DONE;
    assign e.mem_erase = st_q == ST_ERASE;
    assign e.mem_we    = st_q == ST_PROG;
    assign e.mem_space = flash_q;
    assign e.mem_addr  = flash_q ? {base_q[12:2], idx_q} : base_q;
    assign e.mem_wdata = flash_q ? buf_q[idx_q] : {6'h00, ee_q};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence erase_then_prog;
        e.mem_erase ##1 e.mem_we [*4] ##1 e.done;
    endsequence

    block_park_a: assert property (e.start && e.space && e.addr[1:0] != 2'h3 && !e.busy
        |=> e.done && !e.mem_we ##1 !e.busy)
        else $error("early block word touched memory");
    block_prog_a: assert property (st_q == ST_WAIT && tmr_q == '0 && flash_q
        |=> erase_then_prog)
        else $error("block erase and four writes out of order");
    halt_hold_a: assert property (e.start && e.space && e.addr[1:0] == 2'h3 && !e.busy
        |=> e.hold [*2])
        else $error("processor not held during block commit");
endmodule : nvm_commit
`default_nettype wire

//--- design/nvm_ctrl.sv
`default_nettype none
module nvm_ctrl #(
    parameter int unsigned PWRT_CYCLES   = nvm_pkg::PWRT_CYCLES,
    parameter int unsigned COMMIT_CYCLES = nvm_pkg::COMMIT_CYCLES
) (
    // clock and resets
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        por,
    // axi4-lite write
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [11:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // axi4-lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [11:0] araddr,
    input  wire logic [2:0]  arprot,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // processor pipeline
    input  wire logic        instr_step,
    output logic             cpu_squash,
    output logic             cpu_halt,
    // configuration word
    input  wire logic        cfg_data_protect,
    input  wire logic        cfg_code_protect,
    input  wire logic [1:0]  protect_region_select,
    // external programmer pins
    input  wire logic        ext_req,
    input  wire logic        ext_we,
    input  wire logic        ext_space,
    output logic             ext_grant,
    output logic             ext_refuse,
    // memory arrays
    output logic             mem_rd,
    output logic             mem_wr,
    output logic             mem_erase,
    output logic             mem_space,
    output logic [12:0]      mem_addr,
    output logic [13:0]      mem_wdata,
    input  wire logic [13:0] mem_rdata
);
    localparam int unsigned PW = $clog2(PWRT_CYCLES + 1);

    typedef enum logic [1:0] {
        KEY_IDLE  = 2'b00,
        KEY_HALF  = 2'b01,
        KEY_ARMED = 2'b11
    } key_state_t;

    function automatic logic reg_mapped(input logic [9:0] idx);
        reg_mapped = idx == nvm_pkg::IDX_FLAGS || idx == nvm_pkg::IDX_MASK
            || idx == nvm_pkg::IDX_DATA_LO || idx == nvm_pkg::IDX_ADDR_LO
            || idx == nvm_pkg::IDX_DATA_HI || idx == nvm_pkg::IDX_ADDR_HI
            || idx == nvm_pkg::IDX_CTL || idx == nvm_pkg::IDX_KEY;
    endfunction : reg_mapped

    function automatic logic region_hit(input logic [1:0] sel, input logic [12:0] a);
        unique case (sel)
            2'b00: region_hit = a < nvm_pkg::LOCK_END_00;
            2'b01: region_hit = a < nvm_pkg::LOCK_END_01;
            2'b10: region_hit = a < nvm_pkg::LOCK_END_10;
            2'b11: region_hit = 1'b0;
        endcase
    endfunction : region_hit

    nvm_eng_if e ();

    key_state_t  key_q;
    logic        aw_have_q, w_have_q, w_lane_q;
    logic [9:0]  aw_idx_q;
    logic [7:0]  w_byte_q, flags_q, mask_q, data_lo_q, addr_lo_q, rd_word;
    logic [5:0]  data_hi_q;
    logic [4:0]  addr_hi_q;
    logic        space_q, err_q, permit_q, wr_q, rd_q, rd_cap_q;
    logic [1:0]  skip_q, skip_d;
    logic [PW-1:0] pwrt_q;
    logic [2:0]  ext_s1_q, ext_s2_q;
    logic        wr_fire, wr_en, ctl_wr, wr_req, wr_ok, rd_req, req_space, pwrt_done;
    logic        ext_ok;
    logic [12:0] req_addr;

    // write channel joins address and data in either order
    assign wr_fire   = aw_have_q && w_have_q && !bvalid;
    assign wr_en     = wr_fire && w_lane_q && reg_mapped(aw_idx_q);
    assign ctl_wr    = wr_en && aw_idx_q == nvm_pkg::IDX_CTL;
    assign req_space = w_byte_q[nvm_pkg::CTL_SPACE];
    assign req_addr  = req_space ? {addr_hi_q, addr_lo_q} : {5'h00, addr_lo_q};
    assign pwrt_done = pwrt_q == PW'(PWRT_CYCLES);
    assign wr_req    = ctl_wr && w_byte_q[nvm_pkg::CTL_WR] && !wr_q;
    // keys must be the two writes just before, permit set, target not locked
    assign wr_ok     = wr_req && key_q == KEY_ARMED && permit_q && !e.busy && !rd_q
        && (req_space ? !region_hit(protect_region_select, req_addr) : pwrt_done);
    assign rd_req    = ctl_wr && w_byte_q[nvm_pkg::CTL_RD] && !wr_req && !rd_q && !e.busy;

    assign e.start = wr_ok;
    assign e.space = req_space;
    assign e.addr  = req_addr;
    assign e.wdata = {data_hi_q, data_lo_q};

    nvm_commit #(
        .COMMIT_CYCLES (COMMIT_CYCLES)
    ) u_commit (
        .mclk (mclk),
        .rst  (rst),
        .e    (e)
    );

    // axi write side; ready drops while a request is parked
    always_ff @(posedge mclk) begin
        if (rst) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= nvm_pkg::RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_idx_q  <= 10'h000;
            w_byte_q  <= nvm_pkg::REG_RESET;
            w_lane_q  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                awready   <= 1'b0;
                aw_idx_q  <= awaddr[11:2];
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                wready   <= 1'b0;
                w_byte_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= reg_mapped(aw_idx_q) ? nvm_pkg::RESP_OKAY : nvm_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // read mux; the key port is write-only and reads zero
    always_comb begin
        rd_word = 8'h00;
        unique case (araddr[11:2])
            nvm_pkg::IDX_FLAGS:   rd_word = flags_q;
            nvm_pkg::IDX_MASK:    rd_word = mask_q;
            nvm_pkg::IDX_DATA_LO: rd_word = data_lo_q;
            nvm_pkg::IDX_ADDR_LO: rd_word = addr_lo_q;
            nvm_pkg::IDX_DATA_HI: rd_word = {2'h0, data_hi_q};
            nvm_pkg::IDX_ADDR_HI: rd_word = {3'h0, addr_hi_q};
            nvm_pkg::IDX_CTL:     rd_word = {space_q, 3'h0, err_q, permit_q, wr_q, rd_q};
            default:              rd_word = 8'h00;
        endcase
    end

    // axi read side, answer one cycle after the address
    always_ff @(posedge mclk) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= nvm_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_word};
            rresp   <= reg_mapped(araddr[11:2]) ? nvm_pkg::RESP_OKAY : nvm_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // unlock tracker; any other byte-lane-0 write to a mapped register between the keys and the start spoils it
    always_ff @(posedge mclk) begin
        if (rst) begin
            key_q <= KEY_IDLE;
        end else if (wr_en && aw_idx_q == nvm_pkg::IDX_KEY) begin
            if (w_byte_q == nvm_pkg::KEY_FIRST) begin
                key_q <= KEY_HALF;
            end else if (key_q == KEY_HALF && w_byte_q == nvm_pkg::KEY_SECOND) begin
                key_q <= KEY_ARMED;
            end else begin
                key_q <= KEY_IDLE;
            end
        end else if (wr_en) begin
            key_q <= KEY_IDLE;
        end
    end

    // control register; start bits are set-only and cleared by hardware
    always_ff @(posedge mclk) begin
        if (rst) begin
            err_q    <= por ? 1'b0 : (err_q || e.busy);
            permit_q <= 1'b0;
            space_q  <= 1'b0;
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
        end else begin
            if (ctl_wr) begin
                space_q  <= w_byte_q[nvm_pkg::CTL_SPACE];
                err_q    <= w_byte_q[nvm_pkg::CTL_ERR];
                permit_q <= w_byte_q[nvm_pkg::CTL_PERMIT];
            end
            if (wr_ok) begin
                wr_q <= 1'b1;
            end else if (e.done) begin
                wr_q <= 1'b0;
            end
            if (rd_req) begin
                rd_q <= 1'b1;
            end else if (rd_cap_q) begin
                rd_q <= 1'b0;
            end
        end
    end

    // address, data and interrupt-side registers; a capture wins over software
    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_q   <= nvm_pkg::REG_RESET;
            mask_q    <= nvm_pkg::REG_RESET;
            data_lo_q <= nvm_pkg::REG_RESET;
            data_hi_q <= 6'h00;
            addr_lo_q <= nvm_pkg::REG_RESET;
            addr_hi_q <= 5'h00;
        end else begin
            if (wr_en && aw_idx_q == nvm_pkg::IDX_FLAGS) flags_q <= w_byte_q;
            if (wr_en && aw_idx_q == nvm_pkg::IDX_MASK) mask_q <= w_byte_q;
            if (wr_en && aw_idx_q == nvm_pkg::IDX_DATA_LO) data_lo_q <= w_byte_q;
            if (wr_en && aw_idx_q == nvm_pkg::IDX_DATA_HI) data_hi_q <= w_byte_q[5:0];
            if (wr_en && aw_idx_q == nvm_pkg::IDX_ADDR_LO) addr_lo_q <= w_byte_q;
            if (wr_en && aw_idx_q == nvm_pkg::IDX_ADDR_HI) addr_hi_q <= w_byte_q[4:0];
            if (e.done) flags_q[nvm_pkg::FLAG_DONE] <= 1'b1;
            if (rd_cap_q) begin
                data_lo_q <= mem_rdata[7:0];
                data_hi_q <= mem_rdata[13:8];
            end
        end
    end

    // power-up timer restarts with every reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            pwrt_q <= '0;
        end else if (!pwrt_done) begin
            pwrt_q <= pwrt_q + 1'b1;
        end
    end

    // instruction squash count; halting waits until both are squashed
    always_comb begin
        skip_d = skip_q;
        if (wr_ok || (rd_req && req_space)) begin
            skip_d = nvm_pkg::FETCH_SKIP;
        end else if (skip_q != 2'h0 && instr_step) begin
            skip_d = skip_q - 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            skip_q     <= 2'h0;
            cpu_squash <= 1'b0;
            cpu_halt   <= 1'b0;
        end else begin
            skip_q     <= skip_d;
            cpu_squash <= skip_d != 2'h0;
            // release lets the third instruction run
            cpu_halt   <= e.hold && skip_d == 2'h0;
        end
    end

    // programmer pins cross in through two flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_s1_q <= 3'h0;
            ext_s2_q <= 3'h0;
        end else begin
            ext_s1_q <= {ext_space, ext_we, ext_req};
            ext_s2_q <= ext_s1_q;
        end
    end

    assign ext_ok = ext_s2_q[2] ? (!cfg_code_protect && !(ext_s2_q[1] && cfg_data_protect))
                                : !cfg_data_protect;

    // memory strobes, one cycle behind their cause
    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_rd     <= 1'b0;
            mem_wr     <= 1'b0;
            mem_erase  <= 1'b0;
            mem_space  <= 1'b0;
            mem_addr   <= 13'h0000;
            mem_wdata  <= 14'h0000;
            rd_cap_q   <= 1'b0;
            ext_grant  <= 1'b0;
            ext_refuse <= 1'b0;
        end else begin
            mem_rd     <= rd_req;
            mem_wr     <= e.mem_we;
            mem_erase  <= e.mem_erase;
            mem_space  <= rd_req ? req_space : e.mem_space;
            mem_addr   <= rd_req ? req_addr : e.mem_addr;
            mem_wdata  <= e.mem_wdata;
            rd_cap_q   <= mem_rd;
            ext_grant  <= ext_s2_q[0] && ext_ok;
            ext_refuse <= ext_s2_q[0] && !ext_ok;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    key_order_a: assert property (e.start |-> key_q == KEY_ARMED && permit_q)
        else $error("write started without keys or permit");
    pwrt_block_a: assert property (e.start && !e.space |-> pwrt_done)
        else $error("eeprom write during power-up timer");
    squash_two_a: assert property (e.start |=> cpu_squash && skip_q == 2'h2)
        else $error("write start did not squash two instructions");
    no_stall_a: assert property (wr_req && !wr_ok && !e.busy |=> !cpu_halt ##1 !mem_wr)
        else $error("refused start stalled or wrote");
    done_flag_a: assert property (e.done |=> flags_q[nvm_pkg::FLAG_DONE] && !wr_q)
        else $error("completion flag or start bit wrong");
    read_fill_a: assert property (rd_req |=> mem_rd ##1 rd_cap_q ##1 !rd_q
        && data_lo_q == $past(mem_rdata[7:0]))
        else $error("read data not captured two cycles on");
    ext_ee_a: assert property (ext_grant |-> !($past(cfg_data_protect) && !$past(ext_s2_q[2])))
        else $error("external eeprom access granted while protected");
    ext_flash_a: assert property (ext_grant && $past(ext_s2_q[2]) |-> !$past(cfg_code_protect))
        else $error("external flash access granted while protected");
    halt_span_a: assert property (cpu_halt |-> !cpu_squash)
        else $error("halt overlaps squashed instructions");
endmodule : nvm_ctrl
`default_nettype wire

//--- sim/nvm_program_write_control_tb_top.sv
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module nvm_program_write_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PWRT    = 100;
    localparam int unsigned COMMIT  = 8;
    localparam logic [15:0] EXT_TBL = 16'h8b62;
    // bench-driven inputs
    logic        mclk, rst, por, awvalid, wvalid, bready, arvalid, rready, instr_step;
    logic        cfg_data_protect, cfg_code_protect, ext_req, ext_we, ext_space;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [13:0] mem_rdata;
    logic [1:0]  protect_region_select;
    // design outputs
    logic        awready, wready, bvalid, arready, rvalid, cpu_squash, cpu_halt;
    logic        ext_grant, ext_refuse, mem_rd, mem_wr, mem_erase, mem_space;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [12:0] mem_addr;
    logic [13:0] mem_wdata;
    // expectation notes and bookkeeping
    logic [33:0] rq[$];
    logic [27:0] mq[$];
    logic [1:0]  xq[$];
    logic [13:0] aq[$];
    int          n_fail = 0, samples_checked = 0, cyc = 0;
    logic        halt_seen = 1'b0, ext_seen = 1'b0, squash_seen = 1'b0;
    logic [7:0]  al, dl[4];
    logic [4:0]  ah;
    logic [5:0]  dh[4];
    logic [13:0] v;

    nvm_ctrl #(.PWRT_CYCLES(PWRT), .COMMIT_CYCLES(COMMIT)) i_dut (.mclk, .rst, .por, .awvalid,
        .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata,
        .rresp, .instr_step, .cpu_squash, .cpu_halt, .cfg_data_protect, .cfg_code_protect,
        .protect_region_select, .ext_req, .ext_we, .ext_space, .ext_grant, .ext_refuse,
        .mem_rd, .mem_wr, .mem_erase, .mem_space, .mem_addr, .mem_wdata, .mem_rdata);

    // 100 mhz clock
    always #5 mclk = ~mclk;

    // instruction pacing and hang guard
    always @(posedge mclk) begin
        instr_step <= ~instr_step;
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            print_verdict();
        end
    end

    // watcher: each answer retires the oldest note; a stray write finds none
    always @(posedge mclk) begin
        if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front())
        if (mem_wr) `CHK({mem_space, mem_addr, mem_wdata}, mq.size() ? mq.pop_front() : 28'hx)
        if ((ext_grant | ext_refuse) && !ext_seen) `CHK({ext_grant, ext_refuse}, xq.pop_front())
        if (mem_rd | mem_erase) `CHK({mem_space, mem_addr}, aq.pop_front())
        ext_seen <= ext_grant | ext_refuse;
        if (cpu_halt) halt_seen <= 1'b1;
        if (cpu_squash) squash_seen <= 1'b1;
    end

    task automatic axw(input logic [9:0] idx, input logic [7:0] d);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        awaddr  <= {idx, 2'h0};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(a && w)) begin
            @(posedge mclk);
            if (awready) a = 1'b1;
            if (awready) awvalid <= 1'b0;
            if (wready) w = 1'b1;
            if (wready) wvalid <= 1'b0;
        end
        do @(posedge mclk); while (!bvalid);
    endtask : axw

    task automatic axr(input logic [9:0] idx, input logic [7:0] d,
                       input logic [1:0] r = nvm_pkg::RESP_OKAY);
        rq.push_back({r, 24'h0, d});
        araddr  <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
    endtask : axr

    // keys back to back, no other write between them
    task automatic unlock();
        axw(nvm_pkg::IDX_KEY, nvm_pkg::KEY_FIRST);
        axw(nvm_pkg::IDX_KEY, nvm_pkg::KEY_SECOND);
    endtask : unlock

    task automatic print_verdict();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // main sequence; the power-up window is still open for the first start
    initial begin
        void'($urandom(32'h160a1bd2));
        {mclk, awvalid, wvalid, bready, arvalid, rready, instr_step} = '0;
        {cfg_data_protect, cfg_code_protect, ext_req, ext_we, ext_space} = '0;
        {awaddr, araddr, wdata, mem_rdata} = '0;
        protect_region_select = 2'h3;
        {rst, por} = 2'h3;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        por <= 1'b0;
        axr(nvm_pkg::IDX_CTL, 8'h00);
        axw(nvm_pkg::IDX_CTL, 8'h04);
        unlock();
        axw(nvm_pkg::IDX_CTL, 8'h06);
        axr(nvm_pkg::IDX_CTL, 8'h04);
        repeat (PWRT) @(posedge mclk);
        // refused starts: no keys, reversed keys, no permit
        axw(nvm_pkg::IDX_CTL, 8'h06);
        axw(nvm_pkg::IDX_KEY, nvm_pkg::KEY_SECOND);
        axw(nvm_pkg::IDX_KEY, nvm_pkg::KEY_FIRST);
        axw(nvm_pkg::IDX_CTL, 8'h06);
        axr(nvm_pkg::IDX_CTL, 8'h04);
        axw(nvm_pkg::IDX_CTL, 8'h00);
        unlock();
        axw(nvm_pkg::IDX_CTL, 8'h02);
        axr(nvm_pkg::IDX_CTL, 8'h00);
        axr(nvm_pkg::IDX_KEY, 8'h00);
        axr(10'h3ff, 8'h00, nvm_pkg::RESP_SLVERR);
        // eeprom byte write after the power-up window
        al = 8'($urandom);
        dl[0] = 8'($urandom);
        axw(nvm_pkg::IDX_ADDR_HI, 8'h00);
        axw(nvm_pkg::IDX_DATA_HI, 8'h00);
        axw(nvm_pkg::IDX_ADDR_LO, al);
        axw(nvm_pkg::IDX_DATA_LO, dl[0]);
        axw(nvm_pkg::IDX_CTL, 8'h04);
        unlock();
        mq.push_back({1'b0, 5'h0, al, 6'h0, dl[0]});
        axw(nvm_pkg::IDX_CTL, 8'h06);
        repeat (COMMIT + 12) @(posedge mclk);
        axr(nvm_pkg::IDX_CTL, 8'h04);
        axr(nvm_pkg::IDX_FLAGS, 8'h10);
        axw(nvm_pkg::IDX_FLAGS, 8'h00);
        axr(nvm_pkg::IDX_FLAGS, 8'h00);
        `CHK(squash_seen, 1'b1)
        // reset in the middle of an eeprom write leaves the error flag set
        axw(nvm_pkg::IDX_CTL, 8'h04);
        unlock();
        axw(nvm_pkg::IDX_CTL, 8'h06);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        axr(nvm_pkg::IDX_CTL, 8'h08);
        // flash read at an aligned random address
        al = 8'($urandom) & 8'hfc;
        ah = 5'($urandom);
        v = 14'($urandom);
        axw(nvm_pkg::IDX_ADDR_LO, al);
        axw(nvm_pkg::IDX_ADDR_HI, {3'h0, ah});
        mem_rdata <= v;
        aq.push_back({1'b1, ah, al});
        axw(nvm_pkg::IDX_CTL, 8'h81);
        repeat (4) @(posedge mclk);
        axr(nvm_pkg::IDX_DATA_LO, v[7:0]);
        axr(nvm_pkg::IDX_DATA_HI, {2'h0, v[13:8]});
        // four-word block; the last word erases the block and writes all four words to the array
        axw(nvm_pkg::IDX_CTL, 8'h84);
        for (int k = 0; k < 4; k++) begin
            dl[k] = 8'($urandom);
            dh[k] = 6'($urandom);
            axw(nvm_pkg::IDX_ADDR_LO, al | 8'(k));
            axw(nvm_pkg::IDX_DATA_LO, dl[k]);
            axw(nvm_pkg::IDX_DATA_HI, {2'h0, dh[k]});
            unlock();
            if (k == 3) begin
                for (int j = 0; j < 4; j++) mq.push_back({1'b1, ah, al | 8'(j), dh[j], dl[j]});
                aq.push_back({1'b1, ah, al}); // erase hits the block base
            end
            axw(nvm_pkg::IDX_CTL, 8'h86);
            repeat (k == 3 ? COMMIT + 20 : 8) @(posedge mclk);
        end
        `CHK(halt_seen, 1'b1)
        // locked low region: the last word of a block there is refused
        protect_region_select <= 2'h2;
        axw(nvm_pkg::IDX_ADDR_HI, 8'h00);
        axw(nvm_pkg::IDX_ADDR_LO, 8'h03);
        unlock();
        axw(nvm_pkg::IDX_CTL, 8'h86);
        axr(nvm_pkg::IDX_CTL, 8'h84);
        `CHK(mq.size() + aq.size(), 0)
        // external access: one grant, then refusals under code protect and under data protect
        for (int i = 0; i < 4; i++) begin
            {cfg_data_protect, cfg_code_protect, ext_space, ext_we} <= EXT_TBL[4 * i +: 4];
            ext_req <= 1'b1;
            xq.push_back(i == 0 ? 2'h2 : 2'h1);
            repeat (6) @(posedge mclk);
            ext_req <= 1'b0;
            repeat (6) @(posedge mclk);
        end
        print_verdict();
    end
endmodule : nvm_program_write_control_tb_top
`default_nettype wire
